// file: rtl/fps_policy.sv
`timescale 1ns/1ps
// Operation
// - Restore interval starts at an accepted level write or at a bus segment reset.
// - Active on reduced bus, or light sleep on deepest buses, is illegal.
// - Wake event asserted and its context kept only where capability allows.
// - Each state keeps its needed context; uninitialized keeps wake context.
// - Light and deep sleep answer config only and initiate only wake.
// - Powered-down to full on: warm reset, drivers off, only wake kept.
module fps_policy #(
	parameter int DOWN_RECOVERY_CYC  = fps_pkg::DOWN_RECOVERY_CYC,
	parameter int DEEP_RECOVERY_CYC  = fps_pkg::DEEP_RECOVERY_CYC,
	parameter int BASIC_RECOVERY_CYC = fps_pkg::BASIC_RECOVERY_CYC
) (
	// Clock and bus segment reset
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	// Hosting bus state pins
	input  wire logic [1:0]         busStateIn,
	// Power-level field write from config decode
	input  wire logic               levelWrite,
	input  wire logic [1:0]         levelWriteData,
	input  wire logic               initDone,
	// Wake capability per level, and wake requests
	input  wire logic [3:0]         wakeSupport,
	input  wire logic               wakeRequest,
	input  wire logic               wakeClear,
	// State and policy outputs
	output fps_pkg::fps_state_t     funcState,
	output logic      [1:0]         levelField,
	output logic                    acceptConfig,
	output logic                    acceptMemIo,
	output logic                    allowMaster,
	output logic                    allowInterrupt,
	output logic                    allowWake,
	output logic                    wakeEventSignal,
	output logic                    keepWakeContext,
	output logic                    keepFullContext,
	output logic                    driversEnable,
	output logic                    illegalPair,
	output logic                    recoveryBusy
);

	fps_pkg::fps_state_t                  next_funcState;
	logic                [1:0]            next_levelField;
	logic                [fps_pkg::CNT_W-1:0] recCount;
	logic                [fps_pkg::CNT_W-1:0] next_recCount;
	logic                                 warmReset;
	logic                                 next_warmReset;
	logic                                 wakePending;
	logic                                 next_wakePending;
	logic                [1:0]            busState;
	logic                                 next_acceptConfig;
	logic                                 next_acceptMemIo;
	logic                                 next_allowMaster;
	logic                                 next_allowWake;
	logic                                 next_wakeEventSignal;
	logic                                 next_keepWakeContext;
	logic                                 next_keepFullContext;
	logic                                 next_driversEnable;
	logic                                 next_illegalPair;
	logic                                 next_recoveryBusy;
	logic                                 busOn;
	logic                                 capHere;

	// Bus state arrives from pins
	fps_sync3 #(
		.W         (2),
		.RESET_VAL (fps_pkg::BUS_RESET)
	) u_bus_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.pinIn    (busStateIn),
		.cleanOut (busState)
	);

	// State, level field, recovery counter and warm reset
	always_comb begin
		next_funcState  = funcState;
		next_levelField = levelField;
		next_warmReset  = warmReset;
		next_recCount   = recCount;
		if (recCount != '0) begin
			next_recCount = recCount - 1'b1;
		end
		if (recCount == '0) begin
			next_warmReset = 1'b0;
		end
		if (levelWrite && !(funcState == fps_pkg::FPS_DOWN &&
		    levelWriteData != fps_pkg::LVL_FULL_ON)) begin
			next_levelField = levelWriteData;
			// Every accepted write restarts recovery
			next_recCount = fps_pkg::CNT_W'(BASIC_RECOVERY_CYC);
			case (levelWriteData)
			fps_pkg::LVL_FULL_ON: begin
				case (funcState)
				fps_pkg::FPS_DOWN: begin
					next_funcState = fps_pkg::FPS_UNINIT;
					next_warmReset = 1'b1;
					next_recCount  =
						fps_pkg::CNT_W'(DOWN_RECOVERY_CYC);
				end
				fps_pkg::FPS_DEEP: begin
					next_funcState = fps_pkg::FPS_ACTIVE;
					next_recCount  =
						fps_pkg::CNT_W'(DEEP_RECOVERY_CYC);
				end
				fps_pkg::FPS_LIGHT: begin
					next_funcState = fps_pkg::FPS_ACTIVE;
				end
				default: begin
					next_funcState = funcState;
				end
				endcase
			end
			fps_pkg::LVL_LIGHT: begin
				next_funcState = fps_pkg::FPS_LIGHT;
			end
			fps_pkg::LVL_DEEP: begin
				next_funcState = fps_pkg::FPS_DEEP;
			end
			default: begin
				next_funcState = fps_pkg::FPS_DOWN;
			end
			endcase
		end else if (initDone && funcState == fps_pkg::FPS_UNINIT &&
		             !warmReset) begin
			next_funcState = fps_pkg::FPS_ACTIVE;
		end
	end

	// Policy decode for the next cycle
	always_comb begin
		busOn   = (busState == fps_pkg::BUS_FULLY_ON);
		capHere = 1'b0;
		case (next_funcState)
		fps_pkg::FPS_UNINIT,
		fps_pkg::FPS_ACTIVE: capHere = wakeSupport[fps_pkg::LVL_FULL_ON];
		fps_pkg::FPS_LIGHT:  capHere = wakeSupport[fps_pkg::LVL_LIGHT];
		fps_pkg::FPS_DEEP:   capHere = wakeSupport[fps_pkg::LVL_DEEP];
		fps_pkg::FPS_DOWN:   capHere = wakeSupport[fps_pkg::LVL_DOWN_SUPPL];
		default:             capHere = 1'b0;
		endcase
		// Wake context held only where supported; set beats clear
		next_wakePending = capHere &
			(wakeRequest | (wakePending & ~wakeClear));
		// Forbidden pairings of function and bus state
		case (next_funcState)
		fps_pkg::FPS_UNINIT,
		fps_pkg::FPS_ACTIVE: next_illegalPair = !busOn;
		fps_pkg::FPS_LIGHT:  next_illegalPair =
			(busState == fps_pkg::BUS_REDUCED2) ||
			(busState == fps_pkg::BUS_OFF);
		default:             next_illegalPair =
			(busState == fps_pkg::BUS_OFF);
		endcase
		// Target and master gating by state
		next_acceptConfig = busOn && !next_illegalPair && !next_warmReset;
		next_acceptMemIo  = busOn && !next_illegalPair &&
			next_funcState == fps_pkg::FPS_ACTIVE;
		next_allowMaster  = next_acceptMemIo;
		next_allowWake    = capHere && !next_illegalPair &&
			!next_warmReset && next_funcState != fps_pkg::FPS_UNINIT;
		next_wakeEventSignal = next_allowWake && next_wakePending;
		// Context to keep per state
		next_keepWakeContext = capHere ||
			next_funcState == fps_pkg::FPS_UNINIT;
		next_keepFullContext = next_funcState == fps_pkg::FPS_ACTIVE ||
			next_funcState == fps_pkg::FPS_LIGHT ||
			next_funcState == fps_pkg::FPS_DEEP;
		next_driversEnable = !next_warmReset;
		next_recoveryBusy  = (next_recCount != '0);
	end

	// Registers; reset starts the basic restore interval
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			funcState       <= fps_pkg::FPS_UNINIT;
			levelField      <= fps_pkg::LEVEL_RESET;
			recCount        <= fps_pkg::CNT_W'(BASIC_RECOVERY_CYC);
			warmReset       <= 1'b0;
			wakePending     <= 1'b0;
			acceptConfig    <= 1'b0;
			acceptMemIo     <= 1'b0;
			allowMaster     <= 1'b0;
			allowInterrupt  <= 1'b0;
			allowWake       <= 1'b0;
			wakeEventSignal <= 1'b0;
			keepWakeContext <= 1'b1;
			keepFullContext <= 1'b0;
			driversEnable   <= 1'b0;
			illegalPair     <= 1'b0;
			recoveryBusy    <= 1'b1;
		end else begin
			funcState       <= next_funcState;
			levelField      <= next_levelField;
			recCount        <= next_recCount;
			warmReset       <= next_warmReset;
			wakePending     <= next_wakePending;
			acceptConfig    <= next_acceptConfig;
			acceptMemIo     <= next_acceptMemIo;
			allowMaster     <= next_allowMaster;
			allowInterrupt  <= next_allowMaster;
			allowWake       <= next_allowWake;
			wakeEventSignal <= next_wakeEventSignal;
			keepWakeContext <= next_keepWakeContext;
			keepFullContext <= next_keepFullContext;
			driversEnable   <= next_driversEnable;
			illegalPair     <= next_illegalPair;
			recoveryBusy    <= next_recoveryBusy;
		end
	end

endmodule

// file: rtl/fps_sync3.sv
`timescale 1ns/1ps
module fps_sync3 #(
	parameter int         W         = 2,
	parameter logic [1:0] RESET_VAL = 2'h0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	// Pin side and clean side
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] cleanOut
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_cleanOut;

	// Accept a change once stages two and three agree
	always_comb begin
		next_cleanOut = cleanOut;
		if (stage2 == stage3) begin
			next_cleanOut = stage3;
		end
	end

	// Three-stage capture
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1   <= W'(RESET_VAL);
			stage2   <= W'(RESET_VAL);
			stage3   <= W'(RESET_VAL);
			cleanOut <= W'(RESET_VAL);
		end else begin
			stage1   <= pinIn;
			stage2   <= stage1;
			stage3   <= stage2;
			cleanOut <= next_cleanOut;
		end
	end

endmodule

// file: shared/fps_pkg.sv
package fps_pkg;

	// Encodings of the power-level select field
	localparam logic [1:0] LVL_FULL_ON    = 2'h0;
	localparam logic [1:0] LVL_LIGHT      = 2'h1;
	localparam logic [1:0] LVL_DEEP       = 2'h2;
	localparam logic [1:0] LVL_DOWN_SUPPL = 2'h3;

	// Encodings of the hosting bus state
	localparam logic [1:0] BUS_FULLY_ON = 2'h0;
	localparam logic [1:0] BUS_REDUCED1 = 2'h1;
	localparam logic [1:0] BUS_REDUCED2 = 2'h2;
	localparam logic [1:0] BUS_OFF      = 2'h3;

	// Timing
	localparam int CLK_PERIOD_NS      = 40;
	localparam int DEEP_RECOVERY_US   = 20;
	localparam int DOWN_RECOVERY_MS   = 10;
	localparam int DEEP_RECOVERY_CYC  =
		(DEEP_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOWN_RECOVERY_CYC  =
		(DOWN_RECOVERY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BASIC_RECOVERY_CYC = 1;
	localparam int CNT_W              = 18;

	// Reset values
	localparam logic [1:0] LEVEL_RESET = LVL_FULL_ON;
	localparam logic [1:0] BUS_RESET   = BUS_FULLY_ON;

	// Function power states
	typedef enum logic [2:0] {
		FPS_UNINIT,
		FPS_ACTIVE,
		FPS_LIGHT,
		FPS_DEEP,
		FPS_DOWN
	} fps_state_t;

endpackage

// file: sim/fps_host.sv
`timescale 1ns/1ps
module fps_host (
	// Clock and bench command
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [1:0] goData,
	// Function side
	input  wire logic       recoveryBusy,
	output logic            levelWrite,
	output logic [1:0]      levelWriteData
);
	logic       pend = 1'b0;
	logic       ok;
	logic [1:0] pData;

	initial begin
		levelWrite = 1'b0;
		levelWriteData = 2'h0;
	end
	// Holds a write until recovery ends; data wanders while idle
	always @(posedge sys_clk) begin
		if (go) begin
			pend = 1'b1;
			pData = goData;
		end
		ok = !recoveryBusy;
		#1;
		levelWrite = 1'b0;
		levelWriteData = ~levelWriteData;
		if (pend && ok) begin
			levelWrite = 1'b1;
			levelWriteData = pData;
			pend = 1'b0;
		end
	end
endmodule

// file: sim/fps_policy_checker.sv
`timescale 1ns/1ps
module fps_policy_checker #(
	parameter int DOWN_RECOVERY_CYC  = 20,
	parameter int DEEP_RECOVERY_CYC  = 6,
	parameter int BASIC_RECOVERY_CYC = 1
) (
	// Clock, reset and writes
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire logic                levelWrite,
	input wire logic [1:0]          levelWriteData,
	// Policy outputs
	input wire fps_pkg::fps_state_t funcState,
	input wire logic                acceptConfig,
	input wire logic                acceptMemIo,
	input wire logic                allowMaster,
	input wire logic                allowInterrupt,
	input wire logic                allowWake,
	input wire logic                wakeEventSignal,
	input wire logic                keepWakeContext,
	input wire logic                keepFullContext,
	input wire logic                driversEnable,
	input wire logic                illegalPair,
	input wire logic                recoveryBusy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Write of full on from a given level
	sequence s_up(st);
		funcState == st && levelWrite && levelWriteData == 2'h0;
	endsequence
	sequence s_gone;
		!acceptMemIo && !allowMaster && !allowInterrupt;
	endsequence
	property p_ill;
		illegalPair |-> s_gone and !allowWake && !acceptConfig;
	endproperty
	a_ill: assert property (p_ill) else $error("perm in bad pair");
	property p_uninit;
		funcState == fps_pkg::FPS_UNINIT |-> s_gone
			and !allowWake && keepWakeContext;
	endproperty
	a_uninit: assert property (p_uninit) else $error("uninit");
	property p_sleep;
		funcState inside {fps_pkg::FPS_LIGHT, fps_pkg::FPS_DEEP} |-> s_gone;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep gate");
	property p_active;
		funcState == fps_pkg::FPS_ACTIVE |-> keepFullContext;
	endproperty
	a_active: assert property (p_active) else $error("context");
	property p_wake;
		wakeEventSignal |-> allowWake;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not allowed");
	property p_deep;
		s_up(fps_pkg::FPS_DEEP) |=> recoveryBusy [*4];
	endproperty
	a_deep: assert property (p_deep) else $error("deep recovery");
	property p_down;
		s_up(fps_pkg::FPS_DOWN) |=> funcState == fps_pkg::FPS_UNINIT
			##0 (!driversEnable && recoveryBusy) [*8];
	endproperty
	a_down: assert property (p_down) else $error("down exit");
	property p_write;
		levelWrite && funcState != fps_pkg::FPS_DOWN |=> $rose(recoveryBusy)
			or $stable(recoveryBusy) && recoveryBusy;
	endproperty
	a_write: assert property (p_write) else $error("no recovery");
endmodule

bind fps_policy fps_policy_checker #(
	.DOWN_RECOVERY_CYC (DOWN_RECOVERY_CYC),
	.DEEP_RECOVERY_CYC (DEEP_RECOVERY_CYC),
	.BASIC_RECOVERY_CYC(BASIC_RECOVERY_CYC)
) u_chk (.*);

// file: sim/tb_function_power_state_policy.sv
`timescale 1ns/1ps
module tb_function_power_state_policy;
	logic                sys_clk = 1'b0;
	logic                resetn = 1'b0;
	logic [1:0]          busStateIn = 2'h0;
	logic [3:0]          wakeSupport = 4'h0;
	logic                initDone = 1'b0;
	logic                wakeRequest = 1'b0;
	logic                wakeClear = 1'b0;
	logic                go = 1'b0;
	logic [1:0]          goData = 2'h0;
	logic                levelWrite;
	logic [1:0]          levelWriteData, levelField, d;
	logic [3:0]          sup;
	fps_pkg::fps_state_t funcState;
	logic                acceptConfig, acceptMemIo, allowMaster;
	logic                allowInterrupt, allowWake, wakeEventSignal;
	logic                keepWakeContext, keepFullContext, driversEnable;
	logic                illegalPair, recoveryBusy;
	int                  err_count = 0;
	int                  tests_run = 0;
	int                  cyc = 0;
	int                  n;

	fps_policy #(.DOWN_RECOVERY_CYC(20), .DEEP_RECOVERY_CYC(6),
		.BASIC_RECOVERY_CYC(1)) DUT (.*);
	fps_host u_host (.*);

	// Clock and hang guard
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic tick(int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk1(logic got, logic exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chkS(fps_pkg::fps_state_t got, fps_pkg::fps_state_t exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: state %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	// Level write via host; returns after the write edge
	task automatic wr(logic [1:0] v);
		go = 1'b1;
		goData = v;
		tick(1);
		go = 1'b0;
		for (int i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (levelWrite) break;
		end
		#1;
	endtask
	function automatic fps_pkg::fps_state_t exp_lvl(logic [1:0] v);
		return v == 2'h1 ? fps_pkg::FPS_LIGHT : fps_pkg::FPS_DEEP;
	endfunction
	task automatic report_and_stop();
		$display("TB: %0d checks, %0d errors", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(19961));
		tick(10);
		chkS(funcState, fps_pkg::FPS_UNINIT);
		chk1(keepWakeContext, 1'b1);
		chk1(recoveryBusy, 1'b1);
		resetn = 1'b1;
		tick(4);
		chk1(acceptConfig, 1'b1);
		chk1(allowMaster, 1'b0);
		pulse(initDone);
		tick(1);
		chk1(allowMaster, 1'b1);
		chk1(allowInterrupt, 1'b1);
		chk1(acceptMemIo, 1'b1);
		chk1(keepFullContext, 1'b1);
		$display("TB: init test end");
		repeat (8) begin
			sup = 4'($urandom);
			wakeSupport = sup;
			d = 2'(1 + $urandom % 2);
			wr(d);
			tick(1);
			chkS(funcState, exp_lvl(d));
			chk1(acceptMemIo, 1'b0);
			chk1(allowInterrupt, 1'b0);
			chk1(levelField == d, 1'b1);
			chk1(allowWake, sup[d]);
			pulse(wakeRequest);
			tick(1);
			chk1(wakeEventSignal, sup[d]);
			pulse(wakeClear);
			wr(2'h0);
			pulse(initDone);
			tick(8);
			chkS(funcState, fps_pkg::FPS_ACTIVE);
		end
		$display("TB: sleep test end");
		busStateIn = fps_pkg::BUS_REDUCED1;
		tick(8);
		chk1(illegalPair, 1'b1);
		chk1(allowMaster, 1'b0);
		busStateIn = fps_pkg::BUS_FULLY_ON;
		wakeSupport = 4'hf;
		tick(8);
		wr(2'h1);
		for (int b = 0; b < 4; b++) begin
			busStateIn = 2'(b);
			tick(8);
			chk1(illegalPair, b >= 2);
			chk1(acceptConfig, b == 0);
			chk1(allowWake, b < 2);
		end
		busStateIn = fps_pkg::BUS_FULLY_ON;
		tick(8);
		$display("TB: bus test end");
		wr(2'h3);
		tick(1);
		chkS(funcState, fps_pkg::FPS_DOWN);
		wr(2'h0);
		n = 0;
		while (recoveryBusy && n < 100) begin
			tick(1);
			n++;
		end
		chk1(n >= 18, 1'b1);
		tick(3);
		chkS(funcState, fps_pkg::FPS_UNINIT);
		chk1(driversEnable, 1'b1);
		chk1(keepWakeContext, 1'b1);
		$display("TB: down test end");
		pulse(initDone);
		wr(2'h1);
		resetn = 1'b0;
		tick(2);
		chkS(funcState, fps_pkg::FPS_UNINIT);
		chk1(recoveryBusy, 1'b1);
		resetn = 1'b1;
		tick(2);
		chkS(funcState, fps_pkg::FPS_UNINIT);
		chk1(levelField == fps_pkg::LEVEL_RESET, 1'b1);
		chk1(acceptConfig, 1'b1);
		chk1(recoveryBusy, 1'b0);
		$display("TB: reset test end");
		report_and_stop();
	end
endmodule
